// ===== logic/wdt_pkg.sv
// constants shared by the watchdog design files
package wdt_pkg;
  // register map
  localparam logic [7:0] CTRL_ADDR     = 8'h0F;
  localparam logic [7:0] CTRL_POR_INIT = 8'h80;
  // bit positions of watchdog_control
  localparam int COLD_BIT     = 7;
  localparam int IRQ_EN_BIT   = 6;
  localparam int SEL_HI_BIT   = 5;
  localparam int SEL_LO_BIT   = 4;
  localparam int IRQ_FLAG_BIT = 3;
  localparam int RST_FLAG_BIT = 2;
  localparam int RST_EN_BIT   = 1;
  localparam int RESTART_BIT  = 0;
  // interval counter, counts in undivided rc clocks
  localparam int          INT_W       = 21;
  localparam logic [20:0] INT_LAST_00 = 21'h000FFF;
  localparam logic [20:0] INT_LAST_01 = 21'h007FFF;
  localparam logic [20:0] INT_LAST_10 = 21'h03FFFF;
  localparam logic [20:0] INT_LAST_11 = 21'h1FFFFF;
  // reset countdown, 512 rc clocks after timeout
  localparam int         CD_W      = 9;
  localparam logic [8:0] CD_LAST   = 9'h1FF;
endpackage

// ===== logic/wdt_tick_if.sv
// carries the rc clock tick between watchdog modules
`timescale 1ns/100ps
interface wdt_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input  tick);
endinterface

// ===== logic/wdt_counter.sv
// up counter with synchronous clear, clear has priority
`timescale 1ns/100ps
module wdt_counter #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  // control
  input  wire logic         i_clear,
  input  wire logic         i_inc,
  // state
  output logic [W-1:0]      o_count
);

  logic [W-1:0] next_count;

  assign next_count = i_clear ? '0 : (i_inc ? W'(o_count + 1'b1) : o_count);

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_count <= '0;
    else
      o_count <= next_count;
  end

endmodule

// ===== logic/wdt_rc_tick.sv
// samples the rc oscillator pin and marks each rising edge
`timescale 1ns/100ps
module wdt_rc_tick (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  // rc oscillator pin and gating
  input  wire logic i_rc_clk,
  input  wire logic i_rc_osc_enable,
  input  wire logic i_stop_mode,
  // tick out
  wdt_tick_if.src   tick_o
);

  logic [2:0] sync;
  logic       level;
  logic       next_level;
  logic       rose;

  // only second and third stages are inspected
  assign next_level = (sync[1] == sync[2]) ? sync[2] : level;
  assign rose       = next_level & ~level;
  assign tick_o.tick = rose & i_rc_osc_enable & ~i_stop_mode;

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync  <= 3'h0;
      level <= 1'b0;
    end
    else
    begin
      sync  <= {sync[1:0], i_rc_clk};
      level <= next_level;
    end
  end

endmodule

// ===== logic/wdt_top.sv
// watchdog timer with its control register
`timescale 1ns/100ps
module wdt_top (
  // clock and power-on reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // any other reset, one cycle pulse
  input  wire logic       i_sys_rst,
  // register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  output logic      [7:0] o_rd_data,
  // rc oscillator and power state
  input  wire logic       i_rc_clk,
  input  wire logic       i_rc_osc_enable,
  input  wire logic       i_stop_mode,
  // interrupt controller state
  input  wire logic       i_global_irq_enable,
  input  wire logic       i_system_irq_mask,
  input  wire logic       i_irq_in_service,
  // outputs
  output logic            o_wdog_irq,
  output logic            o_wdog_reset
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic                          cold_start;
  logic                          wdog_irq_enable;
  logic [1:0]                    interval_select;
  logic                          wdog_irq_flag;
  logic                          wdog_reset_flag;
  logic                          wdog_reset_enable;
  logic                          cd_active;
  logic [wdt_pkg::INT_W-1:0]     int_count;
  logic [wdt_pkg::CD_W-1:0]      cd_count;

  logic                          next_cold_start;
  logic                          next_irq_enable;
  logic [1:0]                    next_select;
  logic                          next_irq_flag;
  logic                          next_reset_flag;
  logic                          next_reset_enable;
  logic                          next_cd_active;
  logic [7:0]                    next_rd_data;

  ////////////////////////////////////////////////////////////////////////////////
  // rc tick

  wdt_tick_if tick_bus ();

  wdt_rc_tick u_rc_tick (
    .i_sys_clk       (i_sys_clk),
    .i_rst_n         (i_rst_n),
    .i_rc_clk        (i_rc_clk),
    .i_rc_osc_enable (i_rc_osc_enable),
    .i_stop_mode     (i_stop_mode),
    .tick_o          (tick_bus.src)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  wire        ctrl_hit    = (i_addr == wdt_pkg::CTRL_ADDR);
  wire        wr_ctrl     = i_wr_en & ctrl_hit;
  wire        rd_ctrl     = i_rd_en & ctrl_hit;
  wire [1:0]  wr_select   = i_wr_data[wdt_pkg::SEL_HI_BIT:wdt_pkg::SEL_LO_BIT];
  wire        sel_changed = wr_ctrl & (wr_select != interval_select);
  wire        restart_req = wr_ctrl & i_wr_data[wdt_pkg::RESTART_BIT];
  wire        halted      = ~wdog_irq_enable & ~wdog_reset_enable;
  wire        run         = ~halted;
  wire        wake        = wr_ctrl & halted &
                            (i_wr_data[wdt_pkg::IRQ_EN_BIT] | i_wr_data[wdt_pkg::RST_EN_BIT]);
  wire        tick        = tick_bus.tick & run;

  wire [wdt_pkg::INT_W-1:0] int_last =
    (interval_select == 2'h0) ? wdt_pkg::INT_LAST_00 :
    (interval_select == 2'h1) ? wdt_pkg::INT_LAST_01 :
    (interval_select == 2'h2) ? wdt_pkg::INT_LAST_10 : wdt_pkg::INT_LAST_11;

  wire timeout_hit = tick & (int_count == int_last);
  wire fire        = tick & cd_active & wdog_reset_enable &
                     (cd_count == wdt_pkg::CD_LAST);
  wire soft_rst    = i_sys_rst | fire;

  // interval counter clears on restart, wake, timeout, select change outside countdown; countdown on restart, wake, reset enable low
  wire clear_int = soft_rst | timeout_hit | restart_req | wake |
                   (sel_changed & ~cd_active);
  wire clear_cd  = soft_rst | restart_req | wake | ~wdog_reset_enable;

  ////////////////////////////////////////////////////////////////////////////////
  // counters

  wdt_counter #(.W(wdt_pkg::INT_W)) u_int_count (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clear   (clear_int),
    .i_inc     (tick),
    .o_count   (int_count)
  );

  wdt_counter #(.W(wdt_pkg::CD_W)) u_cd_count (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clear   (clear_cd | ~cd_active),
    .i_inc     (tick & cd_active),
    .o_count   (cd_count)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next values

  assign next_cold_start   = wr_ctrl ? i_wr_data[wdt_pkg::COLD_BIT] : cold_start;
  assign next_irq_enable   = wr_ctrl ? i_wr_data[wdt_pkg::IRQ_EN_BIT] : wdog_irq_enable;
  assign next_reset_enable = wr_ctrl ? i_wr_data[wdt_pkg::RST_EN_BIT] : wdog_reset_enable;
  assign next_select       = soft_rst ? 2'h0 : (wr_ctrl ? wr_select : interval_select);
  // hardware set beats software clear
  assign next_irq_flag     = soft_rst    ? 1'b0 :
                             timeout_hit ? 1'b1 :
                             wr_ctrl     ? i_wr_data[wdt_pkg::IRQ_FLAG_BIT] :
                                           wdog_irq_flag;
  assign next_reset_flag   = fire    ? 1'b1 :
                             wr_ctrl ? i_wr_data[wdt_pkg::RST_FLAG_BIT] :
                                       wdog_reset_flag;
  assign next_cd_active    = clear_cd ? 1'b0 :
                             (timeout_hit | cd_active);

  wire [7:0] ctrl_value = {cold_start, wdog_irq_enable, interval_select,
                           wdog_irq_flag, wdog_reset_flag, wdog_reset_enable, 1'b0};
  assign next_rd_data = rd_ctrl ? ctrl_value : 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  // power-on only: cold flag, enables, reset flag
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cold_start        <= wdt_pkg::CTRL_POR_INIT[wdt_pkg::COLD_BIT];
      wdog_irq_enable   <= 1'b0;
      wdog_reset_enable <= 1'b0;
      wdog_reset_flag   <= 1'b0;
    end
    else
    begin
      cold_start        <= next_cold_start;
      wdog_irq_enable   <= next_irq_enable;
      wdog_reset_enable <= next_reset_enable;
      wdog_reset_flag   <= next_reset_flag;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      interval_select <= 2'h0;
      wdog_irq_flag   <= 1'b0;
      cd_active       <= 1'b0;
      o_rd_data       <= 8'h00;
      o_wdog_reset    <= 1'b0;
    end
    else
    begin
      interval_select <= next_select;
      wdog_irq_flag   <= next_irq_flag;
      cd_active       <= next_cd_active;
      o_rd_data       <= next_rd_data;
      o_wdog_reset    <= fire;
    end
  end

  assign o_wdog_irq = wdog_irq_enable & wdog_irq_flag & i_global_irq_enable &
                      i_system_irq_mask & ~i_irq_in_service;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  // tick of the previous cycle, for the countdown check
  logic tick_d;
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tick_d <= 1'b0;
    else
      tick_d <= tick;
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_COLD_KEPT: assert property (
    i_sys_rst && !wr_ctrl |=> cold_start == $past(cold_start))
    else $error("cold-start flag changed on non power-on reset");

  AST_IRQ_RAISE: assert property (
    wdog_irq_flag && wdog_irq_enable && i_global_irq_enable && i_system_irq_mask
    && !i_irq_in_service |-> o_wdog_irq)
    else $error("enabled irq flag did not raise request");

  AST_IRQ_GATED: assert property (
    o_wdog_irq |-> wdog_irq_enable && i_global_irq_enable && !i_irq_in_service)
    else $error("interrupt raised while gated");

  AST_HALT: assert property (
    halted && !wr_ctrl && !i_sys_rst |=> $stable(int_count))
    else $error("counter moved while halted");

  AST_WAKE: assert property (
    wake |=> int_count == '0 && !cd_active)
    else $error("enable from halt did not clear counters");

  AST_ENABLES_KEPT: assert property (
    i_sys_rst && !wr_ctrl |=> $stable(wdog_irq_enable) && $stable(wdog_reset_enable))
    else $error("enable lost on non power-on reset");

  AST_SOFT_CLEAR: assert property (
    i_sys_rst |=> interval_select == 2'h0 && !wdog_irq_flag && !o_rd_data[0])
    else $error("reset did not clear select or irq flag");

  AST_SEL_CD: assert property (
    sel_changed && cd_active && wdog_reset_enable && !restart_req && !soft_rst
    |=> cd_active && int_count == $past(int_count) + tick_d)
    else $error("select write disturbed running countdown");

  AST_TIMEOUT: assert property (
    timeout_hit && !soft_rst |=> wdog_irq_flag ##0 int_count == '0)
    else $error("timeout did not set irq flag");

  AST_FIRE: assert property (
    fire |=> o_wdog_reset && wdog_reset_flag ##1 !o_wdog_reset)
    else $error("watchdog reset pulse or flag wrong");

  AST_NO_FIRE: assert property (
    !wdog_reset_enable |=> !o_wdog_reset)
    else $error("reset issued with reset enable low");

  AST_RESTART: assert property (
    restart_req |=> int_count == '0 && !cd_active)
    else $error("restart did not clear counter");

  AST_CANCEL: assert property (
    cd_active && !wdog_reset_enable |=> !cd_active)
    else $error("pending reset not cancelled");

  AST_CD_START: assert property (
    timeout_hit && wdog_reset_enable && !soft_rst && !restart_req |=> cd_active)
    else $error("timeout did not start reset countdown");

  AST_FIRE_CLEARS: assert property (
    fire |=> interval_select == 2'h0 && !wdog_irq_flag)
    else $error("watchdog reset did not clear select or irq flag");

  AST_FLAG_ONLY_FIRE: assert property (
    !wdog_reset_flag && !fire && !wr_ctrl |=> !wdog_reset_flag)
    else $error("reset flag set without watchdog reset");

  AST_FLAG_KEPT: assert property (
    i_sys_rst && !wr_ctrl && !fire |=> wdog_reset_flag == $past(wdog_reset_flag))
    else $error("reset flag changed on non power-on reset");

  AST_COUNT_BOUND: assert property (
    int_count <= int_last)
    else $error("interval counter passed selected interval");

  AST_RC_GATED: assert property (
    !i_rc_osc_enable || i_stop_mode |-> !tick)
    else $error("tick counted with rc clock gated");

  AST_RD_ZERO: assert property (
    rd_ctrl |=> !o_rd_data[wdt_pkg::RESTART_BIT])
    else $error("restart bit read back as one");

  COV_SEL_IN_CD: cover property (sel_changed && cd_active);
  COV_TIMEOUT: cover property (timeout_hit);
  COV_FIRE:    cover property (fire);
  COV_IRQ:     cover property ($rose(o_wdog_irq));
  COV_CANCEL:  cover property (cd_active ##1 !cd_active && !fire);

endmodule

// ===== test/watchdog_timer_control_bench.sv
// self-checking bench for the watchdog control block
`timescale 1ns/100ps
module watchdog_timer_control_bench;
  logic       i_sys_clk = 1'b0;
  logic       i_rst_n   = 1'b0;
  logic       i_sys_rst = 1'b0;
  logic [7:0] i_addr    = 8'h00;
  logic [7:0] i_wr_data = 8'h00;
  logic       i_wr_en   = 1'b0;
  logic       i_rd_en   = 1'b0;
  logic       i_rc_clk  = 1'b0;
  logic       i_rc_en   = 1'b1;
  logic       i_stop    = 1'b0;
  logic       i_gie     = 1'b1;
  logic       i_mask    = 1'b1;
  logic       i_insvc   = 1'b0;
  logic [7:0] o_rd_data;
  logic       o_wdog_irq;
  logic       o_wdog_reset;
  int         mismatches      = 0;
  int         samples_checked = 0;
  int         resets          = 0;

  always #10 i_sys_clk = ~i_sys_clk;

  wdt_top i_wdt_top (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .o_rd_data(o_rd_data), .i_rc_clk(i_rc_clk), .i_rc_osc_enable(i_rc_en),
    .i_stop_mode(i_stop), .i_global_irq_enable(i_gie), .i_system_irq_mask(i_mask),
    .i_irq_in_service(i_insvc), .o_wdog_irq(o_wdog_irq), .o_wdog_reset(o_wdog_reset)
  );

  // count watchdog reset pulses
  always @(posedge i_sys_clk)
    if (o_wdog_reset === 1'b1)
      resets <= resets + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr_en   <= 1'b1;
    i_addr    <= a;
    i_wr_data <= d;
    @(posedge i_sys_clk);
    i_wr_en   <= 1'b0;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_rd_en <= 1'b1;
    i_addr  <= a;
    @(posedge i_sys_clk);
    i_rd_en <= 1'b0;
    #1 cmp(o_rd_data, e);
  endtask

  // rc clock pulses, four system clocks per half period
  task automatic tick(input int n);
    repeat (n)
    begin
      i_rc_clk <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      i_rc_clk <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    chk_reg(wdt_pkg::CTRL_ADDR, 8'h80);
    chk_reg(8'h10, 8'h00);
    wr(wdt_pkg::CTRL_ADDR, 8'h04);
    repeat (4) @(posedge i_sys_clk);
    cmp(8'(resets), 8'h00);
    wr(wdt_pkg::CTRL_ADDR, 8'h00);
    chk_reg(wdt_pkg::CTRL_ADDR, 8'h00);
  endtask

  task automatic t_timeout_gating;
    wr(wdt_pkg::CTRL_ADDR, 8'h40);
    tick(300);
    wr(wdt_pkg::CTRL_ADDR, 8'h00);
    tick(300);
    wr(wdt_pkg::CTRL_ADDR, 8'h40);
    tick(2000);
    i_rc_en <= 1'b0;
    tick(300);
    i_rc_en <= 1'b1;
    i_stop  <= 1'b1;
    tick(300);
    i_stop  <= 1'b0;
    tick(2095);
    chk_reg(wdt_pkg::CTRL_ADDR, 8'h40);
    tick(1);
    chk_reg(wdt_pkg::CTRL_ADDR, 8'h48);
  endtask

  task automatic t_irq_gating;
    for (int k = 0; k < 8; k++)
    begin
      i_gie   <= k[0];
      i_mask  <= k[1];
      i_insvc <= k[2];
      repeat (2) @(posedge i_sys_clk);
      cmp({7'h00, o_wdog_irq}, {7'h00, k == 3});
    end
    i_gie   <= 1'b1;
    i_mask  <= 1'b1;
    i_insvc <= 1'b0;
    wr(wdt_pkg::CTRL_ADDR, 8'h08);
    #1 cmp({7'h00, o_wdog_irq}, 8'h00);
    wr(wdt_pkg::CTRL_ADDR, 8'h40);
    #1 cmp({7'h00, o_wdog_irq}, 8'h00);
  endtask

  task automatic t_reset_countdown;
    wr(wdt_pkg::CTRL_ADDR, 8'h42);
    tick(1000);
    wr(wdt_pkg::CTRL_ADDR, 8'h43);
    chk_reg(wdt_pkg::CTRL_ADDR, 8'h42);
    tick(4095);
    chk_reg(wdt_pkg::CTRL_ADDR, 8'h42);
    tick(1);
    chk_reg(wdt_pkg::CTRL_ADDR, 8'h4A);
    wr(wdt_pkg::CTRL_ADDR, 8'h5A);
    tick(511);
    cmp(8'(resets), 8'h00);
    tick(1);
    cmp(8'(resets), 8'h01);
    chk_reg(wdt_pkg::CTRL_ADDR, 8'h46);
  endtask

  task automatic t_other_resets;
    wr(wdt_pkg::CTRL_ADDR, 8'h7E);
    #1 cmp({7'h00, o_wdog_irq}, 8'h01);
    @(posedge i_sys_clk);
    i_sys_rst <= 1'b1;
    @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    chk_reg(wdt_pkg::CTRL_ADDR, 8'h46);
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    chk_reg(wdt_pkg::CTRL_ADDR, 8'h80);
    cmp(8'(resets), 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    t_reset_values;
    t_timeout_gating;
    t_irq_gating;
    t_reset_countdown;
    t_other_resets;
    tally_and_finish;
  end

  // cuts a hang short
  initial
  begin
    repeat (95000) @(posedge i_sys_clk);
    mismatches++;
    $display("ERROR %0t: run limit reached", $time);
    tally_and_finish;
  end
endmodule
